// ==== verilog/l2s_pkg.sv ====
// Shared constants and types for the second-level SRAM controller.
// Assumes a single system clock domain and an Avalon-MM register bus.
package l2s_pkg;
	localparam int L2S_BANKS      = 8;
	localparam int L2S_BANK_W     = 3;
	localparam int L2S_WORDS      = 256;
	localparam int L2S_IDX_W      = 8;
	localparam int L2S_ADDR_W     = 14;
	localparam int L2S_ECC_W      = 7;
	localparam int L2S_CORE_W     = 64;
	localparam int L2S_DMA_W      = 32;
	localparam int L2S_WIDE_W     = 64;
	// Bit positions in the byte address
	localparam int L2S_BANK_LSB   = 3;
	localparam int L2S_IDX_LSB    = 6;
	// Register byte addresses
	localparam logic [3:0] L2S_REG_RPC  = 4'h0;
	localparam logic [3:0] L2S_REG_WPC  = 4'h4;
	localparam logic [3:0] L2S_REG_ECC  = 4'h8;
	localparam logic [3:0] L2S_REG_STAT = 4'hC;
	// Reset values of the priority counts and ECC enables
	localparam logic [3:0] L2S_PRIO_RST = 4'h0;
	localparam logic [7:0] L2S_ECC_RST  = 8'hFF;
	// Extra cycles for a narrow access on an ECC bank
	localparam logic [1:0] L2S_NARROW_XTRA = 2'h2;
	// Fields inside a priority register: core count low, DMA count high
	localparam int L2S_PC_CORE_LSB = 0;
	localparam int L2S_PC_DMA_LSB  = 8;
	localparam int L2S_PC_W        = 4;

	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'b00,
		ST_READ  = 2'b01,
		ST_MERGE = 2'b10,
		ST_DONE  = 2'b11
	} l2s_state_type;

	// Even parity over 32 data bits split into check bits
	function automatic logic [6:0] l2s_ecc(input logic [31:0] d);
		logic [6:0] c;
		c = 7'h00;
		for (int i = 0; i < 32; i++)
			c[i % 7] = c[i % 7] ^ d[i];
		return c;
	endfunction
endpackage

// ==== verilog/l2s_bank_if.sv ====
// Request bundle from one channel to the bank array.
// Assumes the array answers reads one cycle after the request.
`timescale 1ns/10ps
interface l2s_bank_if;
	import l2s_pkg::*;
	logic                  req;
	logic                  we;
	logic [L2S_BANK_W-1:0] bank;
	logic [L2S_IDX_W-1:0]  idx;
	logic [63:0]           wdata;
	logic [7:0]            be;
	logic [63:0]           rdata;
	modport chan
	(
		output req, we, bank, idx, wdata, be,
		input  rdata
	);
	modport mem
	(
		input  req, we, bank, idx, wdata, be,
		output rdata
	);
endinterface

// ==== verilog/l2s_bank_mem.sv ====
// Eight banks of 64-bit words with per-32-bit check bits.
// Assumes one request per port per cycle; the caller arbitrates banks.
`timescale 1ns/10ps
module l2s_bank_mem
	import l2s_pkg::*;
(
	input wire logic ref_clk,
	input wire logic clk_en,
	l2s_bank_if.mem  port_a,
	l2s_bank_if.mem  port_b,
	l2s_bank_if.mem  port_c
);
	logic [63:0]          mem_ff [L2S_BANKS*L2S_WORDS];
	logic [13:0]          chk_ff [L2S_BANKS*L2S_WORDS];
	logic [L2S_IDX_W+L2S_BANK_W-1:0] a_loc;
	logic [L2S_IDX_W+L2S_BANK_W-1:0] b_loc;
	logic [L2S_IDX_W+L2S_BANK_W-1:0] c_loc;
	logic [63:0]          a_rd_ff;
	logic [63:0]          b_rd_ff;
	logic [63:0]          c_rd_ff;

	assign a_loc = {port_a.bank, port_a.idx};
	assign b_loc = {port_b.bank, port_b.idx};
	assign c_loc = {port_c.bank, port_c.idx};
	assign port_a.rdata = a_rd_ff;
	assign port_b.rdata = b_rd_ff;
	assign port_c.rdata = c_rd_ff;

	////////////////////////////////////////////////////////////////////////
	// Byte writes and registered read data; check bits track each half
	always_ff @(posedge ref_clk)
	begin
		if (clk_en)
		begin
			if (port_a.req && port_a.we)
			begin
				for (int i = 0; i < 8; i++)
					if (port_a.be[i])
						mem_ff[a_loc][i*8 +: 8] <= port_a.wdata[i*8 +: 8];
				chk_ff[a_loc] <= {l2s_ecc(port_a.wdata[63:32]),
					l2s_ecc(port_a.wdata[31:0])};
			end
			if (port_b.req && port_b.we)
			begin
				for (int i = 0; i < 8; i++)
					if (port_b.be[i])
						mem_ff[b_loc][i*8 +: 8] <= port_b.wdata[i*8 +: 8];
				chk_ff[b_loc] <= {l2s_ecc(port_b.wdata[63:32]),
					l2s_ecc(port_b.wdata[31:0])};
			end
			if (port_a.req && !port_a.we)
				a_rd_ff <= mem_ff[a_loc];
			if (port_b.req && !port_b.we)
				b_rd_ff <= mem_ff[b_loc];
			if (port_c.req && !port_c.we)
				c_rd_ff <= mem_ff[c_loc];
		end
	end
endmodule

// ==== verilog/l2s_ctrl.sv ====
// Second-level SRAM controller: core port, DMA port, bank arbitration.
// Assumes the crossbar holds a request until its ack pulse.
//
// Summary of operation
// - Core port is 64 bits, core only
// - DMA port 32 bits, 64 for fast DMA
// - Separate read and write channel per port
// - Runs on the system clock, half core
// - Reads widened to eight bytes; only narrow ECC writes merged to eight
// - Eight banks, ECC enable per bank
// - Narrow ECC access adds two cycles
// - ECC computed over 32-bit units
// - Narrow ECC write: read then merge
// - Separate read and write priority counts
// - DMA 1, core 0 gives 1-in-3 rate
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
module l2s_ctrl
	import l2s_pkg::*;
#(
	parameter int ADDR_W = L2S_ADDR_W
)
(
	input  wire logic                  ref_clk,
	input  wire logic                  reset,
	input  wire logic                  clk_en,
	// Avalon-MM register slave
	input  wire logic [3:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	// Core read / write channels
	input  wire logic                  core_rd_req,
	input  wire logic [ADDR_W-1:0]     core_rd_addr,
	output logic                       core_rd_ack,
	output logic      [L2S_CORE_W-1:0] core_rd_data,
	input  wire logic                  core_wr_req,
	input  wire logic [ADDR_W-1:0]     core_wr_addr,
	input  wire logic [L2S_CORE_W-1:0] core_wr_data,
	input  wire logic [7:0]            core_wr_be,
	output logic                       core_wr_ack,
	// DMA read / write channels
	input  wire logic                  high_speed_memory_dma,
	input  wire logic                  dma_rd_req,
	input  wire logic [ADDR_W-1:0]     dma_rd_addr,
	output logic                       dma_rd_ack,
	output logic      [L2S_WIDE_W-1:0] dma_rd_data,
	input  wire logic                  dma_wr_req,
	input  wire logic [ADDR_W-1:0]     dma_wr_addr,
	input  wire logic [L2S_WIDE_W-1:0] dma_wr_data,
	input  wire logic [7:0]            dma_wr_be,
	output logic                       dma_wr_ack
);
	// Refuse an address too narrow to reach every word of every bank
	if (ADDR_W < L2S_IDX_LSB + L2S_IDX_W)
	begin : g_addr_chk
		$error("ADDR_W too small for the bank array");
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [15:0] read_priority_count_reg_ff;
	logic [15:0] write_priority_count_reg_ff;
	logic [7:0]  ecc_en_ff;
	logic [7:0]  conflict_cnt_ff;
	logic        avs_ack_ff;

	// Two-cycle answer: waitrequest drops in the cycle after the request
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			avs_ack_ff      <= 1'b0;
			avs_waitrequest <= 1'b1;
		end
		else if (clk_en)
		begin
			avs_ack_ff      <= (avs_read || avs_write) && !avs_ack_ff;
			avs_waitrequest <= !((avs_read || avs_write) && !avs_ack_ff);
		end
	end

	// Software writes the priority counts and bank ECC enables
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			read_priority_count_reg_ff  <= {8'h00, 4'h0, L2S_PRIO_RST};
			write_priority_count_reg_ff <= {8'h00, 4'h0, L2S_PRIO_RST};
			ecc_en_ff                   <= L2S_ECC_RST;
		end
		else if (clk_en && avs_write && avs_ack_ff)
		begin
			case (avs_address)
				L2S_REG_RPC: read_priority_count_reg_ff <= avs_writedata[15:0];
				L2S_REG_WPC: write_priority_count_reg_ff <= avs_writedata[15:0];
				L2S_REG_ECC: ecc_en_ff <= avs_writedata[7:0];
				default: ;
			endcase
		end
	end

	// Read mux; unmapped offsets read zero
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			avs_readdata <= 32'h0000_0000;
		else if (clk_en && avs_read && !avs_ack_ff)
		begin
			case (avs_address)
				L2S_REG_RPC:  avs_readdata <= {16'h0000, read_priority_count_reg_ff};
				L2S_REG_WPC:  avs_readdata <= {16'h0000, write_priority_count_reg_ff};
				L2S_REG_ECC:  avs_readdata <= {24'h000000, ecc_en_ff};
				L2S_REG_STAT: avs_readdata <= {24'h000000, conflict_cnt_ff};
				default:      avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	logic [3:0] core_read_priority_count;
	logic [3:0] dma_read_priority_count;
	logic [3:0] core_write_priority_count;
	logic [3:0] dma_write_priority_count;
	assign core_read_priority_count =
		read_priority_count_reg_ff[L2S_PC_CORE_LSB +: L2S_PC_W];
	assign dma_read_priority_count =
		read_priority_count_reg_ff[L2S_PC_DMA_LSB +: L2S_PC_W];
	assign core_write_priority_count =
		write_priority_count_reg_ff[L2S_PC_CORE_LSB +: L2S_PC_W];
	assign dma_write_priority_count =
		write_priority_count_reg_ff[L2S_PC_DMA_LSB +: L2S_PC_W];

	////////////////////////////////////////////////////////////////////////
	// Address decode helpers
	function automatic logic [L2S_BANK_W-1:0] bank_of(input logic [ADDR_W-1:0] a);
		return a[L2S_BANK_LSB +: L2S_BANK_W];
	endfunction
	function automatic logic [L2S_IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
		return a[L2S_IDX_LSB +: L2S_IDX_W];
	endfunction
	// Narrow means the bytes touched do not cover whole 32-bit halves
	function automatic logic is_narrow(input logic [7:0] be);
		return !((be[3:0] == 4'hF || be[3:0] == 4'h0) &&
			(be[7:4] == 4'hF || be[7:4] == 4'h0));
	endfunction

	// DMA data narrows to 32 bits unless the fast DMA drives the request
	logic [63:0] dma_wd_eff;
	logic [7:0]  dma_be_eff;
	always_comb
	begin
		dma_wd_eff = dma_wr_data;
		dma_be_eff = dma_wr_be;
		if (!high_speed_memory_dma)
		begin
			dma_wd_eff = dma_wr_addr[2] ? {dma_wr_data[31:0], 32'h0000_0000}
				: {32'h0000_0000, dma_wr_data[31:0]};
			dma_be_eff = dma_wr_addr[2] ? {dma_wr_be[3:0], 4'h0}
				: {4'h0, dma_wr_be[3:0]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bank arbitration: read pair and write pair each share a grant
	// counter; reads to different banks never stall each other, writes share one array port.
	logic rd_conf;
	logic wr_conf;
	logic rd_dma_turn_ff;
	logic wr_dma_turn_ff;
	logic [3:0] rd_run_ff;
	logic [3:0] wr_run_ff;
	logic core_rd_go;
	logic dma_rd_go;
	logic core_wr_go;
	logic dma_wr_go;
	logic core_wr_busy;
	logic dma_wr_busy;

	assign rd_conf = core_rd_req && dma_rd_req &&
		bank_of(core_rd_addr) == bank_of(dma_rd_addr);
	assign wr_conf = core_wr_req && dma_wr_req &&
		bank_of(core_wr_addr) == bank_of(dma_wr_addr);

	// Each side keeps the turn for count+1 conflict cycles with no ack: core 0 / DMA 1 yields DMA
	// two of three slots, one 64-bit access every three cycles
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			rd_dma_turn_ff <= 1'b0;
			rd_run_ff      <= 4'h0;
		end
		else if (clk_en && rd_conf && !core_rd_ack && !dma_rd_ack)
		begin
			if (rd_run_ff >= (rd_dma_turn_ff ? dma_read_priority_count
				: core_read_priority_count))
			begin
				rd_dma_turn_ff <= !rd_dma_turn_ff;
				rd_run_ff      <= 4'h0;
			end
			else
				rd_run_ff <= rd_run_ff + 4'h1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			wr_dma_turn_ff <= 1'b0;
			wr_run_ff      <= 4'h0;
		end
		else if (clk_en && wr_conf && !core_wr_busy && !dma_wr_busy)
		begin
			if (wr_run_ff >= (wr_dma_turn_ff ? dma_write_priority_count
				: core_write_priority_count))
			begin
				wr_dma_turn_ff <= !wr_dma_turn_ff;
				wr_run_ff      <= 4'h0;
			end
			else
				wr_run_ff <= wr_run_ff + 4'h1;
		end
	end

	assign core_rd_go = core_rd_req && !core_rd_ack &&
		(!rd_conf || !rd_dma_turn_ff);
	assign dma_rd_go = dma_rd_req && !dma_rd_ack &&
		(!rd_conf || rd_dma_turn_ff);
	assign core_wr_go = core_wr_req && !core_wr_busy &&
		(!wr_conf || !wr_dma_turn_ff);
	assign dma_wr_go = dma_wr_req && !dma_wr_busy &&
		(!wr_conf || wr_dma_turn_ff);

	always_ff @(posedge ref_clk)
	begin
		if (reset)
			conflict_cnt_ff <= 8'h00;
		else if (clk_en && (rd_conf || wr_conf))
			conflict_cnt_ff <= conflict_cnt_ff + 8'h01;
	end

	////////////////////////////////////////////////////////////////////////
	// Read channels: one read port of the array each, narrow ECC reads
	// stretch by two cycles
	l2s_bank_if rd_if ();
	l2s_bank_if drd_if ();
	l2s_bank_if wr_if ();
	logic [1:0] core_rd_wait_ff;
	logic [1:0] dma_rd_wait_ff;
	logic       core_rd_pend_ff;
	logic       dma_rd_pend_ff;

	// A read port per channel: a shared port would stall reads that go
	// to different banks
	assign rd_if.req    = core_rd_go;
	assign rd_if.we     = 1'b0;
	assign rd_if.bank   = bank_of(core_rd_addr);
	assign rd_if.idx    = idx_of(core_rd_addr);
	assign rd_if.wdata  = 64'h0;
	assign rd_if.be     = 8'h00;
	assign drd_if.req   = dma_rd_go;
	assign drd_if.we    = 1'b0;
	assign drd_if.bank  = bank_of(dma_rd_addr);
	assign drd_if.idx   = idx_of(dma_rd_addr);
	assign drd_if.wdata = 64'h0;
	assign drd_if.be    = 8'h00;

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			core_rd_pend_ff <= 1'b0;
			dma_rd_pend_ff  <= 1'b0;
			core_rd_wait_ff <= 2'h0;
			dma_rd_wait_ff  <= 2'h0;
			core_rd_ack     <= 1'b0;
			dma_rd_ack      <= 1'b0;
			core_rd_data    <= 64'h0;
			dma_rd_data     <= 64'h0;
		end
		else if (clk_en)
		begin
			core_rd_ack <= 1'b0;
			dma_rd_ack  <= 1'b0;
			if (core_rd_go && !core_rd_pend_ff)
			begin
				core_rd_pend_ff <= 1'b1;
				core_rd_wait_ff <= 2'h0;
			end
			else if (core_rd_pend_ff)
			begin
				core_rd_pend_ff <= 1'b0;
				core_rd_ack     <= 1'b1;
				core_rd_data    <= rd_if.rdata;
			end
			if (dma_rd_go && !dma_rd_pend_ff)
			begin
				dma_rd_pend_ff <= 1'b1;
				dma_rd_wait_ff <= (!high_speed_memory_dma &&
					ecc_en_ff[bank_of(dma_rd_addr)]) ? 2'h0 : L2S_NARROW_XTRA;
			end
			else if (dma_rd_pend_ff && dma_rd_wait_ff != L2S_NARROW_XTRA)
				dma_rd_wait_ff <= dma_rd_wait_ff + 2'h1;
			else if (dma_rd_pend_ff)
			begin
				dma_rd_pend_ff <= 1'b0;
				dma_rd_ack     <= 1'b1;
				dma_rd_data    <= high_speed_memory_dma ? drd_if.rdata
					: {32'h0, dma_rd_addr[2] ? drd_if.rdata[63:32]
					: drd_if.rdata[31:0]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write channel: full 32-bit units write at once; narrow writes to an
	// ECC bank read the word, merge, then write (three cycles)
	l2s_state_type state_ff;
	logic          wr_dma_ff;
	logic          wr_ack_ff;

	assign core_wr_busy = state_ff != ST_IDLE || core_wr_ack;
	assign dma_wr_busy  = state_ff != ST_IDLE || dma_wr_ack;

	logic        w_dma;
	logic [63:0] w_data;
	logic [7:0]  w_be;
	logic [ADDR_W-1:0] w_addr;
	assign w_dma  = (state_ff == ST_IDLE) ? (dma_wr_go && !core_wr_go) : wr_dma_ff;
	assign w_data = w_dma ? dma_wd_eff : core_wr_data;
	assign w_be   = w_dma ? dma_be_eff : core_wr_be;
	assign w_addr = w_dma ? dma_wr_addr : core_wr_addr;

	// Array write port; the merge read uses the write port's read path
	assign wr_if.bank = bank_of(w_addr);
	assign wr_if.idx  = idx_of(w_addr);
	assign wr_if.req  = (state_ff == ST_IDLE && (core_wr_go || dma_wr_go) &&
		!(is_narrow(w_be) && ecc_en_ff[bank_of(w_addr)])) ||
		state_ff == ST_READ || state_ff == ST_MERGE;
	assign wr_if.we   = state_ff != ST_READ;
	// Merge keeps unwritten bytes so check bits cover whole 32-bit units
	always_comb
	begin
		wr_if.wdata = w_data;
		wr_if.be    = w_be;
		if (state_ff == ST_MERGE)
		begin
			for (int i = 0; i < 8; i++)
				wr_if.wdata[i*8 +: 8] = w_be[i] ? w_data[i*8 +: 8]
					: wr_if.rdata[i*8 +: 8];
			wr_if.be = 8'hFF;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			state_ff    <= ST_IDLE;
			wr_dma_ff   <= 1'b0;
			core_wr_ack <= 1'b0;
			dma_wr_ack  <= 1'b0;
		end
		else if (clk_en)
		begin
			core_wr_ack <= 1'b0;
			dma_wr_ack  <= 1'b0;
			case (state_ff)
				ST_IDLE:
					if (core_wr_go || dma_wr_go)
					begin
						wr_dma_ff <= w_dma;
						if (is_narrow(w_be) && ecc_en_ff[bank_of(w_addr)])
							state_ff <= ST_READ;
						else if (w_dma)
							dma_wr_ack <= 1'b1;
						else
							core_wr_ack <= 1'b1;
					end
				ST_READ: state_ff <= ST_MERGE;
				ST_MERGE:
				begin
					state_ff    <= ST_IDLE;
					dma_wr_ack  <= wr_dma_ff;
					core_wr_ack <= !wr_dma_ff;
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	l2s_bank_mem u_mem
	(
		.ref_clk (ref_clk),
		.clk_en  (clk_en),
		.port_a  (rd_if.mem),
		.port_b  (wr_if.mem),
		.port_c  (drd_if.mem)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_merge;
		state_ff == ST_READ ##1 state_ff == ST_MERGE;
	endsequence
	a_merge_three: assert property (@(posedge ref_clk) disable iff (reset)
		(clk_en && state_ff == ST_READ) |-> s_merge)
		else $error("merge write did not follow read");
	a_wr_ack_one: assert property (@(posedge ref_clk) disable iff (reset)
		!(core_wr_ack && dma_wr_ack))
		else $error("two write acks at once");
	a_rd_bank_share: assert property (@(posedge ref_clk) disable iff (reset)
		rd_conf |-> !(core_rd_go && dma_rd_go))
		else $error("same-bank reads granted together");
	a_parallel_go: assert property (@(posedge ref_clk) disable iff (reset)
		(core_rd_req && !core_rd_ack && !rd_conf) |-> core_rd_go)
		else $error("core read stalled without conflict");
	a_dma_parallel: assert property (@(posedge ref_clk) disable iff (reset)
		(dma_rd_req && !dma_rd_ack && !rd_conf) |-> dma_rd_go)
		else $error("DMA read stalled without conflict");
	a_core_rd_lat: assert property (@(posedge ref_clk) disable iff (reset)
		(clk_en && core_rd_go && !core_rd_pend_ff) |=> clk_en [*1] ##0
		core_rd_pend_ff)
		else $error("core read not pending");
	a_ack_pulse: assert property (@(posedge ref_clk) disable iff (reset)
		core_rd_ack |=> !core_rd_ack)
		else $error("core read ack held");
	a_turn_switch: assert property (@(posedge ref_clk) disable iff (reset)
		(clk_en && rd_conf && !core_rd_ack && !dma_rd_ack &&
		rd_run_ff >= (rd_dma_turn_ff ? dma_read_priority_count
		: core_read_priority_count)) |=> $changed(rd_dma_turn_ff))
		else $error("turn not passed after count");
	a_bus_wait: assert property (@(posedge ref_clk) disable iff (reset)
		(clk_en && avs_read && avs_waitrequest) |=> !avs_waitrequest)
		else $error("register read not answered");
endmodule

// ==== verification/l2s_xbar_model.sv ====
// Crossbar master model driving one request channel of the controller.
// Assumes the channel answers a held request with a one-cycle ack pulse.
`timescale 1ns/10ps
module l2s_xbar_model
	import l2s_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        go,
	input  wire logic        again,
	input  wire logic [13:0] a_in,
	input  wire logic [63:0] d_in,
	input  wire logic [7:0]  be_in,
	input  wire logic        ack,
	output logic             req_ff,
	output logic      [13:0] addr_ff,
	output logic      [63:0] wdata_ff,
	output logic      [7:0]  be_ff,
	output logic      [7:0]  lat_ff,
	output logic      [15:0] acks_ff
);
	logic [7:0] wait_ff;

	////////////////////////////////////////////////////////////////////////
	// Request held until ack is sampled; with again high the next request
	// follows at once, else lines are released inverted so a stale address
	// can never pass for a live one
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			req_ff  <= 1'b0;
			addr_ff <= 14'h0000;
			acks_ff <= 16'h0000;
		end
		else if (req_ff && ack && again)
		begin
			addr_ff  <= a_in;
			wdata_ff <= d_in;
			be_ff    <= be_in;
			acks_ff  <= acks_ff + 16'h0001;
		end
		else if (req_ff && ack)
		begin
			req_ff   <= 1'b0;
			addr_ff  <= ~addr_ff;
			wdata_ff <= ~wdata_ff;
			be_ff    <= ~be_ff;
			acks_ff  <= acks_ff + 16'h0001;
		end
		else if (!req_ff && (go || again))
		begin
			req_ff   <= 1'b1;
			addr_ff  <= a_in;
			wdata_ff <= d_in;
			be_ff    <= be_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Cycles from request to ack, latched at the ack edge
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			lat_ff <= 8'h00;
		if (reset || !req_ff)
			wait_ff <= 8'h00;
		else if (ack)
		begin
			lat_ff  <= wait_ff;
			wait_ff <= 8'h00;
		end
		else
			wait_ff <= wait_ff + 8'h01;
	end
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the second-level SRAM controller.
// Assumes one system clock; channels 0..3 are core rd, core wr, dma rd, wr.
`timescale 1ns/10ps
module tb;
	import l2s_pkg::*;
	logic        ref_clk;
	logic        reset;
	logic        hs;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        go[4];
	logic        again[4];
	logic [13:0] a_in[4];
	logic [63:0] d_in[4];
	logic [7:0]  be_in[4];
	logic        req[4];
	logic [13:0] addr[4];
	logic [63:0] wdata[4];
	logic [7:0]  be[4];
	logic        ack[4];
	logic [7:0]  lat[4];
	logic [15:0] acks[4];
	logic [15:0] kk[4];
	logic [63:0] core_rd_data;
	logic [63:0] dma_rd_data;
	logic [31:0] q;
	int          mismatches;
	int          comparisons;
	int          d1;

	////////////////////////////////////////////////////////////////////////
	// Design and one crossbar model per channel
	l2s_ctrl DUT
	(
		.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.core_rd_req(req[0]), .core_rd_addr(addr[0]),
		.core_rd_ack(ack[0]), .core_rd_data(core_rd_data),
		.core_wr_req(req[1]), .core_wr_addr(addr[1]),
		.core_wr_data(wdata[1]), .core_wr_be(be[1]),
		.core_wr_ack(ack[1]), .high_speed_memory_dma(hs),
		.dma_rd_req(req[2]), .dma_rd_addr(addr[2]),
		.dma_rd_ack(ack[2]), .dma_rd_data(dma_rd_data),
		.dma_wr_req(req[3]), .dma_wr_addr(addr[3]),
		.dma_wr_data(wdata[3]), .dma_wr_be(be[3]), .dma_wr_ack(ack[3])
	);
	for (genvar i = 0; i < 4; i++)
	begin : g_m
		l2s_xbar_model u_model
		(
			.ref_clk(ref_clk), .reset(reset), .go(go[i]),
			.again(again[i]), .a_in(a_in[i]), .d_in(d_in[i]),
			.be_in(be_in[i]), .ack(ack[i]), .req_ff(req[i]),
			.addr_ff(addr[i]), .wdata_ff(wdata[i]), .be_ff(be[i]),
			.lat_ff(lat[i]), .acks_ff(acks[i])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Shared tasks: compare, register bus, channel requests
	function automatic logic [13:0] mk(input logic [2:0] b,
		input logic [7:0] i, input logic h);
		return {i, b, h, 2'b00};
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Bus cycle held until waitrequest is sampled low
	task automatic avs(input logic wr, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50)
			mismatches++;
	endtask
	task automatic put(input int c, input logic [13:0] a,
		input logic [63:0] d, input logic [7:0] b);
		kk[c] = acks[c];
		go[c] <= 1'b1;
		a_in[c] <= a;
		d_in[c] <= d;
		be_in[c] <= b;
	endtask
	task automatic fire();
		@(posedge ref_clk);
		for (int i = 0; i < 4; i++)
			go[i] <= 1'b0;
	endtask
	task automatic wait_ack(input int c);
		int n;
		n = 0;
		while (acks[c] === kk[c] && n < 50)
		begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 50)
			mismatches++;
	endtask
	task automatic one(input int c, input logic [13:0] a,
		input logic [63:0] d, input logic [7:0] b);
		@(posedge ref_clk);
		put(c, a, d, b);
		fire();
		wait_ack(c);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_regs();
		avs(0, L2S_REG_RPC, 0); chk(q, 0);
		avs(0, L2S_REG_ECC, 0); chk(q, 32'h0000_00FF);
		avs(1, L2S_REG_WPC, 32'h0000_0302);
		avs(0, L2S_REG_WPC, 0); chk(q, 32'h0000_0302);
		avs(1, 4'h6, 32'hFFFF_FFFF);
		avs(0, 4'h6, 0); chk(q, 0);
		avs(1, L2S_REG_WPC, 32'h0000_0000);
	endtask
	// Full write, narrow merge on an ECC bank, then with ECC off
	task automatic t_core();
		one(1, mk(0, 5, 0), 64'h0123456789ABCDEF, 8'hFF);
		chk(lat[1], 1);
		one(1, mk(0, 5, 0), 64'hFFFFFFFFFFFFFFFF, 8'h02);
		chk(lat[1], 3);
		one(0, mk(0, 5, 0), 0, 0);
		chk(lat[0], 2);
		chk(core_rd_data, 64'h0123456789ABFFEF);
		avs(1, L2S_REG_ECC, 32'h0000_00FE);
		one(1, mk(0, 5, 0), 0, 8'h01);
		chk(lat[1], 1);
		avs(1, L2S_REG_ECC, 32'h0000_00FF);
	endtask
	// Wide and narrow DMA reads of a word placed by the DMA write port
	task automatic t_dma();
		hs <= 1'b1;
		one(3, mk(1, 2, 0), 64'hCAFEF00D12345678, 8'hFF);
		one(2, mk(1, 2, 0), 0, 0);
		chk(lat[2], 2);
		chk(dma_rd_data, 64'hCAFEF00D12345678);
		hs <= 1'b0;
		one(2, mk(1, 2, 1), 0, 0);
		chk(lat[2], 4);
		chk(dma_rd_data[31:0], 32'hCAFEF00D);
		hs <= 1'b1;
	endtask
	// Three channels on three banks in the same cycle
	task automatic t_par();
		@(posedge ref_clk);
		put(0, mk(0, 5, 0), 0, 0);
		put(1, mk(2, 1, 0), 64'h1, 8'hFF);
		put(2, mk(1, 2, 0), 0, 0);
		fire();
		for (int c = 0; c < 3; c++)
			wait_ack(c);
		chk(lat[0], 2);
		chk(lat[1], 1);
		chk(lat[2], 2);
	endtask
	// Sustained same-bank reads; returns DMA acks over 60 cycles
	task automatic conflict(input logic [31:0] rpc, output int dn);
		int k;
		avs(1, L2S_REG_RPC, rpc);
		@(posedge ref_clk);
		put(0, mk(3, 0, 0), 0, 0);
		put(2, mk(3, 1, 0), 0, 0);
		again[0] <= 1'b1;
		again[2] <= 1'b1;
		fire();
		repeat (6) @(posedge ref_clk);
		k = acks[2];
		repeat (60) @(posedge ref_clk);
		dn = acks[2] - k;
		again[0] <= 1'b0;
		again[2] <= 1'b0;
		repeat (20) @(posedge ref_clk);
	endtask
	task automatic t_conf();
		int d2;
		conflict(32'h0000_0100, d1);
		chk(d1 >= 18, 1);
		conflict(32'h0000_0003, d2);
		chk(d2 < d1, 1);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Clock, reset, sequence, watchdog and verdict
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic final_report();
		if (mismatches == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		#200000;
		mismatches++;
		final_report();
	end
	initial
	begin
		mismatches = 0;
		comparisons = 0;
		reset = 1'b1;
		hs = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		for (int i = 0; i < 4; i++)
		begin
			go[i] = 1'b0;
			again[i] = 1'b0;
			a_in[i] = 14'h0000;
			d_in[i] = 64'h0;
			be_in[i] = 8'h00;
		end
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		t_regs();
		t_core();
		t_dma();
		t_par();
		t_conf();
		final_report();
	end
endmodule
